/* File: core/hsm_pkg.sv */
// Purpose: Constants for the hot swap supervisor and power monitor core.
// Assumes: 32-bit Avalon-MM register bus, word aligned byte addresses.
// Notes: Offsets are byte addresses; every register is one word.
package hsm_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [5:0] HSM_OFS_CTRL = 6'h00;
  localparam logic [5:0] HSM_OFS_STATUS = 6'h04;
  localparam logic [5:0] HSM_OFS_INT_STAT = 6'h08;
  localparam logic [5:0] HSM_OFS_INT_MASK = 6'h0C;
  localparam logic [5:0] HSM_OFS_IOUT = 6'h10;
  localparam logic [5:0] HSM_OFS_VIN = 6'h14;
  localparam logic [5:0] HSM_OFS_LOAD_SIDE_VOLTAGE_PIN = 6'h18;
  localparam logic [5:0] HSM_OFS_PIN = 6'h1C;
  localparam logic [5:0] HSM_OFS_EIN_ACC = 6'h20;
  localparam logic [5:0] HSM_OFS_EIN_CNT = 6'h24;
  localparam logic [5:0] HSM_OFS_PK_IOUT = 6'h28;
  localparam logic [5:0] HSM_OFS_PK_VIN = 6'h2C;
  localparam logic [5:0] HSM_OFS_PK_LOAD_SIDE_VOLTAGE_PIN = 6'h30;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int HSM_CTRL_RUN = 0;
  localparam int HSM_CTRL_VRANGE = 1;
  localparam int HSM_CTRL_VSRC = 2;
  localparam int HSM_CTRL_AVG_LO = 4;
  localparam int HSM_CTRL_ALERT_EN = 8;
  localparam int HSM_CTRL_CLR_PEAK = 9;
  localparam int HSM_CTRL_CLR_EIN = 10;
  localparam logic [31:0] HSM_CTRL_RESET = 32'h0000_0101;

  // ----------------------------------------------------------------
  // Interrupt / status bit positions
  // ----------------------------------------------------------------
  localparam int HSM_EV_LOW_SUPPLY = 0;
  localparam int HSM_EV_HIGH_SUPPLY = 1;
  localparam int HSM_EV_FET_BAD = 2;
  localparam int HSM_EV_GOOD_RISE = 3;
  localparam int HSM_EV_FAULT = 4;
  localparam int HSM_EV_CONV_DONE = 5;
  localparam int HSM_EV_W = 6;

  // ----------------------------------------------------------------
  // Measurement widths
  // ----------------------------------------------------------------
  localparam int HSM_ADC_W = 12;
  localparam int HSM_AVG_MAX = 7;
  localparam int HSM_PWR_W = 25;

  // ----------------------------------------------------------------
  // Controller states (Gray along off, on, fault, rearm)
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    HSM_ST_OFF = 2'b00,
    HSM_ST_RUN = 2'b01,
    HSM_ST_FAULT = 2'b11,
    HSM_ST_REARM = 2'b10
  } hsm_state_t;

endpackage

/* File: core/hsm_core.sv */
// Purpose: Supervisor and power monitor logic of a hot swap controller.
// Assumes: Comparator and ADC results arrive synchronous to clk_i.
// Notes: Registers reached over Avalon-MM with one wait state.
//
// Chosen here: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module hsm_core
  import hsm_pkg::*;
#(
  parameter int ADC_W = HSM_ADC_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Avalon-MM slave
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Digitized comparators and hardware enable
  input wire logic low_supply_input_i,
  input wire logic high_supply_input_i,
  input wire logic enable_i,
  input wire logic flb_above_thr_i,
  input wire logic flb_below_hyst_i,
  input wire logic sense_over_2mv_i,
  input wire logic gate_below_vth_i,
  input wire logic timer_high_i,
  input wire logic timer_low_i,
  // ADC samples
  input wire logic adc_valid_i,
  input wire logic signed [ADC_W-1:0] adc_current_i,
  input wire logic [ADC_W-1:0] adc_voltage_i,
  // Gate and analog steering
  output logic gate_on_o,
  output logic hyst_source_en_o,
  output logic vrange_high_o,
  output logic vsrc_load_side_o,
  // Open-drain pins
  output logic output_good_flag_o,
  output logic output_good_flag_oe_o,
  output logic aux_output_pin_two_o,
  output logic aux_output_pin_two_oe_o,
  // Interrupt
  output logic irq_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int SUM_W = ADC_W + HSM_AVG_MAX + 1;
  hsm_state_t state_q;
  logic [31:0] ctrl_q;
  logic [HSM_EV_W-1:0] int_stat_q, int_mask_q, ev_set;
  logic ack_q, wr_fire, rd_cap;
  logic [31:0] rd_mux, ein_cnt_shadow_q;
  logic supply_ok, start_ok, off_seen_q;
  logic fet_bad_q, good_q, hyst_q;
  logic low_prev_q, high_prev_q, fet_prev_q, good_prev_q;
  logic [7:0] avg_cnt_q, avg_last;
  logic [2:0] avg_n;
  logic signed [SUM_W-1:0] cur_sum_q, cur_tot;
  logic [SUM_W-1:0] v_sum_q, v_tot;
  logic avg_done_q;
  logic signed [ADC_W-1:0] iout_q;
  logic [ADC_W-1:0] vin_q, load_side_voltage_pin_q, vnew;
  logic signed [HSM_PWR_W-1:0] pin_q;
  logic pwr_go_q;
  logic [31:0] ein_acc_q;
  logic [7:0] ein_roll_q;
  logic [23:0] ein_cnt_q;
  logic [32:0] ein_sum;
  logic signed [ADC_W-1:0] pk_iout_q;
  logic [ADC_W-1:0] pk_vin_q, pk_load_side_voltage_pin_q;
  logic pk_i_vld_q, pk_vi_vld_q, pk_vo_vld_q;
  logic clr_peak, clr_ein;

  // ----------------------------------------------------------------
  // Bus slave: one wait state, write at the completing edge
  // ----------------------------------------------------------------
  // Request is held until the cycle after it is first seen
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
  assign wr_fire = avs_write_i & ack_q;
  assign rd_cap = avs_read_i & ~ack_q;

  // Acknowledge toggles to end each access
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
    end
  end

  // Read data mux, unmapped addresses read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (avs_address_i)
      HSM_OFS_CTRL: rd_mux = ctrl_q & 32'h0000_0177;
      HSM_OFS_STATUS: rd_mux = {25'h0, state_q, supply_ok, hyst_q,
                                good_q, fet_bad_q, gate_on_o};
      HSM_OFS_INT_STAT: rd_mux = {26'h0, int_stat_q};
      HSM_OFS_INT_MASK: rd_mux = {26'h0, int_mask_q};
      HSM_OFS_IOUT: rd_mux = {{(32-ADC_W){iout_q[ADC_W-1]}}, iout_q};
      HSM_OFS_VIN: rd_mux = {{(32-ADC_W){1'b0}}, vin_q};
      HSM_OFS_LOAD_SIDE_VOLTAGE_PIN: rd_mux = {{(32-ADC_W){1'b0}}, load_side_voltage_pin_q};
      HSM_OFS_PIN: rd_mux = {{(32-HSM_PWR_W){pin_q[HSM_PWR_W-1]}}, pin_q};
      HSM_OFS_EIN_ACC: rd_mux = ein_acc_q;
      HSM_OFS_EIN_CNT: rd_mux = ein_cnt_shadow_q;
      HSM_OFS_PK_IOUT: rd_mux = {{(32-ADC_W){pk_iout_q[ADC_W-1]}},
                                 pk_iout_q};
      HSM_OFS_PK_VIN: rd_mux = {{(32-ADC_W){1'b0}}, pk_vin_q};
      HSM_OFS_PK_LOAD_SIDE_VOLTAGE_PIN: rd_mux = {{(32-ADC_W){1'b0}}, pk_load_side_voltage_pin_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data captured in the wait cycle
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (rd_cap) begin
      avs_readdata_o <= rd_mux;
    end
  end

  // Count and rollover frozen together with the accumulator read
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ein_cnt_shadow_q <= 32'h0000_0000;
    end else if (rd_cap && avs_address_i == HSM_OFS_EIN_ACC) begin
      ein_cnt_shadow_q <= {ein_roll_q, ein_cnt_q};
    end
  end

  // ----------------------------------------------------------------
  // Control, interrupt status and mask registers
  // ----------------------------------------------------------------
  assign clr_peak = wr_fire && avs_address_i == HSM_OFS_CTRL &&
                    avs_writedata_i[HSM_CTRL_CLR_PEAK];
  assign clr_ein = wr_fire && avs_address_i == HSM_OFS_CTRL &&
                   avs_writedata_i[HSM_CTRL_CLR_EIN];
  assign avg_n = ctrl_q[HSM_CTRL_AVG_LO +: 3];
  assign vrange_high_o = ctrl_q[HSM_CTRL_VRANGE];
  assign vsrc_load_side_o = ctrl_q[HSM_CTRL_VSRC];

  // Control word, clear bits are pulses and not stored
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_q <= HSM_CTRL_RESET;
    end else if (wr_fire && avs_address_i == HSM_OFS_CTRL) begin
      ctrl_q <= avs_writedata_i & 32'h0000_0177;
    end
  end

  // Mask register
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      int_mask_q <= '0;
    end else if (wr_fire && avs_address_i == HSM_OFS_INT_MASK) begin
      int_mask_q <= avs_writedata_i[HSM_EV_W-1:0];
    end
  end

  // Sticky events, a new event wins over a write-one clear
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      int_stat_q <= '0;
    end else if (wr_fire && avs_address_i == HSM_OFS_INT_STAT) begin
      int_stat_q <= (int_stat_q & ~avs_writedata_i[HSM_EV_W-1:0]) | ev_set;
    end else begin
      int_stat_q <= int_stat_q | ev_set;
    end
  end

  // Level interrupt
  assign irq_o = |(int_stat_q & int_mask_q);

  // ----------------------------------------------------------------
  // Event edge detection
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      low_prev_q <= 1'b0;
      high_prev_q <= 1'b0;
      fet_prev_q <= 1'b0;
      good_prev_q <= 1'b0;
    end else begin
      low_prev_q <= low_supply_input_i;
      high_prev_q <= high_supply_input_i;
      fet_prev_q <= fet_bad_q;
      good_prev_q <= good_q;
    end
  end

  always_comb begin
    ev_set = '0;
    ev_set[HSM_EV_LOW_SUPPLY] = low_prev_q & ~low_supply_input_i;
    ev_set[HSM_EV_HIGH_SUPPLY] = ~high_prev_q & high_supply_input_i;
    ev_set[HSM_EV_FET_BAD] = fet_bad_q & ~fet_prev_q;
    ev_set[HSM_EV_GOOD_RISE] = good_q & ~good_prev_q;
    ev_set[HSM_EV_FAULT] = (state_q == HSM_ST_RUN) & timer_high_i;
    ev_set[HSM_EV_CONV_DONE] = avg_done_q;
  end

  // ----------------------------------------------------------------
  // Hot swap controller
  // ----------------------------------------------------------------
  // Low input high means above 1 V; high input high means above 1 V
  assign supply_ok = low_supply_input_i & ~high_supply_input_i;
  assign start_ok = supply_ok & enable_i & ctrl_q[HSM_CTRL_RUN];

  // Records an off phase of the low input or the on bit
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      off_seen_q <= 1'b0;
    end else if (state_q == HSM_ST_FAULT) begin
      off_seen_q <= 1'b0;
    end else if (!low_supply_input_i || !ctrl_q[HSM_CTRL_RUN]) begin
      off_seen_q <= 1'b1;
    end
  end

  // Controller state; gate drive only in the on state
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= HSM_ST_OFF;
    end else begin
      unique case (state_q)
        HSM_ST_OFF: begin
          if (start_ok) begin
            state_q <= HSM_ST_RUN;
          end
        end
        HSM_ST_RUN: begin
          if (timer_high_i) begin
            state_q <= HSM_ST_FAULT;
          end else if (!start_ok) begin
            state_q <= HSM_ST_OFF;
          end
        end
        HSM_ST_FAULT: begin
          if (timer_low_i) begin
            state_q <= HSM_ST_REARM;
          end
        end
        HSM_ST_REARM: begin
          if (off_seen_q && low_supply_input_i && ctrl_q[HSM_CTRL_RUN]) begin
            state_q <= HSM_ST_OFF;
          end
        end
      endcase
    end
  end

  assign gate_on_o = (state_q == HSM_ST_RUN) & start_ok;

  // ----------------------------------------------------------------
  // Output good, hysteresis source, FET health and alert
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      good_q <= 1'b0;
      hyst_q <= 1'b0;
      fet_bad_q <= 1'b0;
    end else begin
      good_q <= flb_above_thr_i;
      if (flb_above_thr_i) begin
        hyst_q <= 1'b1;
      end else if (flb_below_hyst_i) begin
        hyst_q <= 1'b0;
      end
      fet_bad_q <= ~gate_on_o & sense_over_2mv_i & gate_below_vth_i;
    end
  end

  // Open-drain pins drive low only
  assign output_good_flag_o = 1'b0;
  assign output_good_flag_oe_o = ~good_q;
  assign hyst_source_en_o = hyst_q;
  assign aux_output_pin_two_o = 1'b0;
  assign aux_output_pin_two_oe_o = ctrl_q[HSM_CTRL_ALERT_EN] & fet_bad_q;

  // ----------------------------------------------------------------
  // Averaging
  // ----------------------------------------------------------------
  // Last sample index of the block and the running totals
  assign avg_last = 8'((9'h001 << avg_n) - 9'h001);
  assign cur_tot = cur_sum_q + SUM_W'(adc_current_i);
  assign v_tot = v_sum_q + SUM_W'(adc_voltage_i);

  // Sums and sample count; result is total shifted by N
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      avg_cnt_q <= 8'h00;
      cur_sum_q <= '0;
      v_sum_q <= '0;
      avg_done_q <= 1'b0;
      iout_q <= '0;
      vnew <= '0;
    end else begin
      avg_done_q <= 1'b0;
      if (adc_valid_i) begin
        if (avg_cnt_q >= avg_last) begin
          avg_cnt_q <= 8'h00;
          cur_sum_q <= '0;
          v_sum_q <= '0;
          avg_done_q <= 1'b1;
          iout_q <= ADC_W'(cur_tot >>> avg_n);
          vnew <= ADC_W'(v_tot >> avg_n);
        end else begin
          avg_cnt_q <= avg_cnt_q + 8'h01;
          cur_sum_q <= cur_tot;
          v_sum_q <= v_tot;
        end
      end
    end
  end

  // Averaged voltage goes to the selected source register
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      vin_q <= '0;
      load_side_voltage_pin_q <= '0;
      pwr_go_q <= 1'b0;
    end else begin
      pwr_go_q <= avg_done_q & ~vsrc_load_side_o;
      if (avg_done_q) begin
        if (vsrc_load_side_o) begin
          load_side_voltage_pin_q <= vnew;
        end else begin
          vin_q <= vnew;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Power and energy
  // ----------------------------------------------------------------
  // Negative power is not accumulated
  assign ein_sum = {1'b0, ein_acc_q} +
                   (pin_q[HSM_PWR_W-1] ? 33'h0 : 33'(pin_q));

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_q <= '0;
    end else if (pwr_go_q) begin
      pin_q <= HSM_PWR_W'($signed({1'b0, vin_q}) * iout_q);
    end
  end

  // Accumulator, rollover count and sample count move together
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ein_acc_q <= 32'h0000_0000;
      ein_roll_q <= 8'h00;
      ein_cnt_q <= 24'h00_0000;
    end else if (clr_ein) begin
      ein_acc_q <= 32'h0000_0000;
      ein_roll_q <= 8'h00;
      ein_cnt_q <= 24'h00_0000;
    end else if (avg_done_q && !vsrc_load_side_o) begin
      // Uses the power of the previous block, one per measurement
      ein_acc_q <= ein_sum[31:0];
      ein_roll_q <= ein_roll_q + {7'h00, ein_sum[32]};
      ein_cnt_q <= ein_cnt_q + 24'h00_0001;
    end
  end

  // ----------------------------------------------------------------
  // Peak hold
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pk_iout_q <= '0;
      pk_vin_q <= '0;
      pk_load_side_voltage_pin_q <= '0;
      pk_i_vld_q <= 1'b0;
      pk_vi_vld_q <= 1'b0;
      pk_vo_vld_q <= 1'b0;
    end else if (clr_peak) begin
      pk_i_vld_q <= 1'b0;
      pk_vi_vld_q <= 1'b0;
      pk_vo_vld_q <= 1'b0;
    end else if (pwr_go_q || (avg_done_q && vsrc_load_side_o)) begin
      // Compare the freshly stored averages: with avg_done_q on the load side, one cycle later (pwr_go_q) on the input side
      if (!pk_i_vld_q || iout_q > pk_iout_q) begin
        pk_iout_q <= iout_q;
      end
      pk_i_vld_q <= 1'b1;
      if (pwr_go_q && (!pk_vi_vld_q || vin_q > pk_vin_q)) begin
        pk_vin_q <= vin_q;
      end
      if (pwr_go_q) begin
        pk_vi_vld_q <= 1'b1;
      end
      if (!pwr_go_q && (!pk_vo_vld_q || vnew > pk_load_side_voltage_pin_q)) begin
        pk_load_side_voltage_pin_q <= vnew;
      end
      if (!pwr_go_q) begin
        pk_vo_vld_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_low_supply_gate: assert property (
    !low_supply_input_i |-> !gate_on_o)
    else $error("gate on with low supply under reference");
  a_high_supply_gate: assert property (
    high_supply_input_i |-> !gate_on_o)
    else $error("gate on with high supply over reference");
  a_start_needs_ok: assert property (
    (state_q == HSM_ST_OFF) ##1 (state_q == HSM_ST_RUN) |->
      $past(supply_ok) && $past(enable_i))
    else $error("start without enable and supply window");
  a_enable_holds_off: assert property (
    !enable_i |-> !gate_on_o)
    else $error("gate on while enable low");
  a_good_follows_thr: assert property (
    flb_above_thr_i |=> !output_good_flag_oe_o)
    else $error("output good not released above threshold");
  a_hyst_holds: assert property (
    hyst_q && !flb_below_hyst_i |=> hyst_source_en_o)
    else $error("hysteresis source dropped early");
  a_fet_bad_cause: assert property (
    fet_bad_q |-> !$past(gate_on_o) && $past(sense_over_2mv_i) &&
      $past(gate_below_vth_i))
    else $error("fet bad without all three conditions");
  a_alert_on_bad: assert property (
    fet_bad_q && ctrl_q[HSM_CTRL_ALERT_EN] |-> aux_output_pin_two_oe_o)
    else $error("alert not driven for bad fet");
  a_energy_count: assert property (
    avg_done_q && !vsrc_load_side_o && !clr_ein |=>
      ein_cnt_q == $past(ein_cnt_q) + 24'h00_0001)
    else $error("energy sample count not advanced");
  a_rearm_waits: assert property (
    state_q == HSM_ST_FAULT && !timer_low_i |=> state_q == HSM_ST_FAULT)
    else $error("fault left before timer low");
  a_avg_passthru: assert property (
    adc_valid_i && avg_n == 3'h0 |=> avg_done_q && iout_q ==
      $past(adc_current_i))
    else $error("single sample not passed through");
  a_peak_monotone: assert property (
    pk_i_vld_q && !clr_peak |=> pk_iout_q >= $past(pk_iout_q))
    else $error("current peak decreased without clear");
  a_bus_one_wait: assert property (
    $rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("read did not complete after one wait");

  c_power_up: cover property (
    state_q == HSM_ST_OFF ##1 state_q == HSM_ST_RUN);
  c_fault_rearm: cover property (
    state_q == HSM_ST_REARM ##1 state_q == HSM_ST_OFF);
  c_avg_block: cover property (avg_done_q && avg_n == 3'h3);
  c_fet_alert: cover property ($rose(aux_output_pin_two_oe_o));

endmodule
`default_nettype wire

/* File: bench/hsm_fet_model.sv */
// Purpose: Far-side model: pass FET, sense resistor and monitor ADC.
// Assumes: Gate follows the drive command.
// Notes: Sample lines scramble outside valid cycles.
`timescale 1ns/1ps
`default_nettype none
module hsm_fet_model
  import hsm_pkg::*;
(
  // Clock and bench stimulus
  input wire logic clk_i,
  input wire logic gate_on_i,
  input wire logic shorted_i,
  input wire logic smp_req_i,
  input wire logic signed [HSM_ADC_W-1:0] smp_cur_i,
  input wire logic [HSM_ADC_W-1:0] smp_vol_i,
  // Pins seen by the controller
  output logic gate_below_vth_o,
  output logic sense_over_2mv_o,
  output logic adc_valid_o,
  output logic signed [HSM_ADC_W-1:0] adc_current_o,
  output logic [HSM_ADC_W-1:0] adc_voltage_o
);
  // Undriven gate sits low; a shorted FET still carries current
  assign gate_below_vth_o = !gate_on_i;
  assign sense_over_2mv_o = shorted_i | gate_on_i;
  // One-cycle sample strobe; data toggles when not valid
  always_ff @(posedge clk_i) begin
    adc_valid_o <= smp_req_i;
    adc_current_o <= smp_req_i ? smp_cur_i : ~adc_current_o;
    adc_voltage_o <= smp_req_i ? smp_vol_i : ~adc_voltage_o;
  end
endmodule
`default_nettype wire

/* File: bench/hsm_core_test.sv */
// Purpose: Self-checking bench for the supervisor core.
// Assumes: The FET model stands on the far side.
// Notes: The bench acts as register host.
`timescale 1ns/1ps
`default_nettype none
module hsm_core_test import hsm_pkg::*;;
  logic clk_i, rstn_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [5:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rd;
  logic low_supply_input_i, high_supply_input_i, enable_i, flb_above_thr_i;
  logic flb_below_hyst_i, sense_over_2mv_i, gate_below_vth_i, timer_high_i;
  logic timer_low_i, adc_valid_i, gate_on_o, hyst_source_en_o, vrange_high_o;
  logic vsrc_load_side_o, output_good_flag_o, output_good_flag_oe_o, irq_o;
  logic aux_output_pin_two_o, aux_output_pin_two_oe_o, shorted, smp_req;
  logic signed [HSM_ADC_W-1:0] adc_current_i, smp_cur;
  logic [HSM_ADC_W-1:0] adc_voltage_i, smp_vol;
  int mismatches, n_compared;

  // Device under test and its far side
  hsm_core dut (.clk_i, .rstn_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .low_supply_input_i,
    .high_supply_input_i, .enable_i, .flb_above_thr_i, .flb_below_hyst_i,
    .sense_over_2mv_i, .gate_below_vth_i, .timer_high_i, .timer_low_i,
    .adc_valid_i, .adc_current_i, .adc_voltage_i, .gate_on_o, .hyst_source_en_o,
    .vrange_high_o, .vsrc_load_side_o, .output_good_flag_o,
    .output_good_flag_oe_o, .aux_output_pin_two_o, .aux_output_pin_two_oe_o,
    .irq_o);
  hsm_fet_model far (.clk_i, .gate_on_i(gate_on_o), .shorted_i(shorted),
    .smp_req_i(smp_req), .smp_cur_i(smp_cur), .smp_vol_i(smp_vol),
    .gate_below_vth_o(gate_below_vth_i), .sense_over_2mv_o(sense_over_2mv_i),
    .adc_valid_o(adc_valid_i), .adc_current_o(adc_current_i),
    .adc_voltage_o(adc_voltage_i));

  // Clock at 25 MHz
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic is(input logic b, input logic e);
    chk({31'h0, b}, {31'h0, e});
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  // Bus access: hold until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (n >= 20) chk(32'h0, 32'h1);
  endtask
  task automatic rdreg(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic sample(input logic [11:0] c, input logic [11:0] v);
    @(posedge clk_i);
    smp_req <= 1'b1;
    smp_cur <= c;
    smp_vol <= v;
    @(posedge clk_i) smp_req <= 1'b0;
  endtask

  // Start conditions and supply window
  task automatic t_power();
    rdreg(HSM_OFS_CTRL, HSM_CTRL_RESET);
    @(posedge clk_i) low_supply_input_i <= 1'b1;
    settle(3);
    is(gate_on_o, 1'b0);
    @(posedge clk_i) enable_i <= 1'b1;
    settle(3);
    is(gate_on_o, 1'b1);
    @(posedge clk_i) low_supply_input_i <= 1'b0;
    settle(0);
    is(gate_on_o, 1'b0);
    @(posedge clk_i) low_supply_input_i <= 1'b1;
    settle(3);
    @(posedge clk_i) high_supply_input_i <= 1'b1;
    settle(0);
    is(gate_on_o, 1'b0);
    @(posedge clk_i) high_supply_input_i <= 1'b0;
    settle(3);
    is(gate_on_o, 1'b1);
  endtask
  // Output good with hysteresis, then shorted FET alert
  task automatic t_good_fet();
    @(posedge clk_i) flb_below_hyst_i <= 1'b0;
    @(posedge clk_i) flb_above_thr_i <= 1'b1;
    settle(2);
    is(output_good_flag_oe_o, 1'b0);
    is(hyst_source_en_o, 1'b1);
    @(posedge clk_i) flb_above_thr_i <= 1'b0;
    settle(2);
    is(output_good_flag_oe_o, 1'b1);
    is(hyst_source_en_o, 1'b1);
    @(posedge clk_i) flb_below_hyst_i <= 1'b1;
    settle(2);
    is(hyst_source_en_o, 1'b0);
    @(posedge clk_i) shorted <= 1'b1;
    settle(3);
    is(aux_output_pin_two_oe_o, 1'b0);
    @(posedge clk_i) enable_i <= 1'b0;
    settle(3);
    is(aux_output_pin_two_oe_o, 1'b1);
    @(posedge clk_i) shorted <= 1'b0;
    @(posedge clk_i) enable_i <= 1'b1;
  endtask
  // Readings, power, energy, peaks, averaging
  task automatic t_meter();
    sample(12'h007, 12'h01E);
    settle(5);
    rdreg(HSM_OFS_VIN, 32'h1E);
    rdreg(HSM_OFS_PIN, 32'hD2);
    sample(12'hFFB, 12'h014);
    settle(5);
    rdreg(HSM_OFS_IOUT, 32'hFFFF_FFFB);
    rdreg(HSM_OFS_EIN_ACC, 32'hD2);
    rdreg(HSM_OFS_EIN_CNT, 32'h2);
    rdreg(HSM_OFS_PK_IOUT, 32'h7);
    bus(1'b1, HSM_OFS_CTRL, 32'h113);
    sample(12'h006, 12'h00A);
    sample(12'h002, 12'h014);
    settle(5);
    is(vrange_high_o, 1'b1);
    rdreg(HSM_OFS_IOUT, 32'h4);
    rdreg(HSM_OFS_VIN, 32'hF);
    rdreg(HSM_OFS_PK_VIN, 32'h1E);
    bus(1'b1, HSM_OFS_CTRL, 32'h717);
    sample(12'h002, 12'h008);
    sample(12'h002, 12'h008);
    settle(5);
    is(vsrc_load_side_o, 1'b1);
    rdreg(HSM_OFS_LOAD_SIDE_VOLTAGE_PIN, 32'h8);
    rdreg(HSM_OFS_PK_IOUT, 32'h2);
    bus(1'b1, HSM_OFS_CTRL, 32'h171);
    for (int k = 0; k < 128; k++) sample(k[0] ? 12'h065 : 12'h064, 12'h028);
    settle(5);
    rdreg(HSM_OFS_IOUT, 32'h64);
    rdreg(HSM_OFS_PIN, 32'hFA0);
    rdreg(HSM_OFS_EIN_ACC, 32'h3C);
    rdreg(HSM_OFS_EIN_CNT, 32'h1);
  endtask
  // Interrupt mask and clear, unmapped read, latched fault
  task automatic t_irq_fault();
    bus(1'b1, HSM_OFS_INT_STAT, 32'h3F);
    bus(1'b1, HSM_OFS_INT_MASK, 32'h20);
    bus(1'b1, HSM_OFS_CTRL, 32'h101);
    sample(12'h001, 12'h001);
    settle(3);
    is(irq_o, 1'b1);
    bus(1'b1, HSM_OFS_INT_MASK, 32'h0);
    settle(0);
    is(irq_o, 1'b0);
    bus(1'b1, HSM_OFS_INT_STAT, 32'h20);
    bus(1'b1, HSM_OFS_INT_MASK, 32'h30);
    settle(0);
    is(irq_o, 1'b0);
    rdreg(6'h3C, 32'h0);
    @(posedge clk_i) timer_low_i <= 1'b0;
    @(posedge clk_i) timer_high_i <= 1'b1;
    settle(3);
    is(gate_on_o, 1'b0);
    is(irq_o, 1'b1);
    @(posedge clk_i) timer_high_i <= 1'b0;
    @(posedge clk_i) timer_low_i <= 1'b1;
    settle(3);
    is(gate_on_o, 1'b0);
    rdreg(HSM_OFS_STATUS, 32'h50);
    bus(1'b1, HSM_OFS_CTRL, 32'h100);
    bus(1'b1, HSM_OFS_CTRL, 32'h101);
    settle(3);
    is(gate_on_o, 1'b1);
  endtask

  task automatic results();
    if (mismatches == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    #120000;
    mismatches++;
    results();
  end
  // Main sequence
  initial begin
    {rstn_i, avs_read_i, avs_write_i, low_supply_input_i, enable_i} = '0;
    {high_supply_input_i, flb_above_thr_i, timer_high_i, shorted} = '0;
    {smp_req, avs_address_i, avs_writedata_i, smp_cur, smp_vol} = '0;
    flb_below_hyst_i = 1'b1;
    timer_low_i = 1'b1;
    mismatches = 0;
    n_compared = 0;
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_power();
    t_good_fet();
    t_meter();
    t_irq_fault();
    results();
  end
endmodule
`default_nettype wire
